/* core/ofrr_cfg.svh */
// Offsets, field positions, reset values and delay decode for the fault reaction block
`ifndef OFRR_CFG_SVH
`define OFRR_CFG_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define OFRR_REG_OFFSET 8'h41
`define OFRR_REG_RESET 8'h80

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OFRR_MODE_HI 7
`define OFRR_MODE_LO 6
`define OFRR_RETRY_HI 5
`define OFRR_RETRY_LO 3
`define OFRR_DELAY_HI 2
`define OFRR_DELAY_LO 0

// ----------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------
`define OFRR_MODE_IGNORE 2'h0
`define OFRR_MODE_DELAYED 2'h1
`define OFRR_MODE_SHUTDOWN 2'h2
`define OFRR_MODE_WHILE_PRESENT 2'h3
`define OFRR_RETRY_NONE 3'h0
`define OFRR_RETRY_ENDLESS 3'h7

// ----------------------------------------------------------------
// Delay code to number of time units
// ----------------------------------------------------------------
`define OFRR_UNITS_0 8'h01
`define OFRR_UNITS_1 8'h02
`define OFRR_UNITS_2 8'h04
`define OFRR_UNITS_3 8'h10
`define OFRR_UNITS_4 8'h08
`define OFRR_UNITS_5 8'h20
`define OFRR_UNITS_6 8'h40
`define OFRR_UNITS_7 8'h80

`endif

/* core/ofrr_pkg.sv */
// Types shared by the fault reaction block
package ofrr_pkg;

  // ----------------------------------------------------------------
  // Controller states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    OFRR_RUN     = 6'b000001,
    OFRR_DLYRUN  = 6'b000010,
    OFRR_HOLD    = 6'b000100,
    OFRR_WAIT    = 6'b001000,
    OFRR_TRY     = 6'b010000,
    OFRR_LATCH   = 6'b100000
  } ofrr_state_e;

  typedef logic [7:0] ofrr_units_t;

endpackage

/* core/ofrr_delay_timer.sv */
// Delay timer counting external time-unit ticks for a decoded delay code
`include "ofrr_cfg.svh"

module ofrr_delay_timer
  import ofrr_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, high
  input wire logic start, // Load and start, pulse
  input wire logic unit_tick, // One delay time unit elapsed
  input wire logic [2:0] code, // Delay code
  output logic done, // Delay expired, pulse
  output logic busy // Timer running
);

  ofrr_units_t cnt_r, cnt_nxt, load_val;
  logic busy_r, busy_nxt, done_r, done_nxt;

  // ----------------------------------------------------------------
  // Decode and count
  // ----------------------------------------------------------------
  // Code to unit count; code 4 has no printed value, 8 fills the gap
  always_comb begin
    case (code)
      3'h0: load_val = `OFRR_UNITS_0;
      3'h1: load_val = `OFRR_UNITS_1;
      3'h2: load_val = `OFRR_UNITS_2;
      3'h3: load_val = `OFRR_UNITS_3;
      3'h4: load_val = `OFRR_UNITS_4;
      3'h5: load_val = `OFRR_UNITS_5;
      3'h6: load_val = `OFRR_UNITS_6;
      default: load_val = `OFRR_UNITS_7;
    endcase
  end

  // Start always restarts, so a new attempt never inherits old time
  always_comb begin
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (start) begin
      cnt_nxt = load_val;
      busy_nxt = 1'b1;
    end else if (busy_r && unit_tick) begin
      if (cnt_r == 8'h01) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 8'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;
  assign busy = busy_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  load_count_a: assert property (@(posedge clk) disable iff (rst)
    start |=> (busy_r && cnt_r == $past(load_val)))
    else $error("timer did not load decoded unit count");

  expire_a: assert property (@(posedge clk) disable iff (rst)
    (!start && busy_r && unit_tick && cnt_r == 8'h01) |=> (done_r && !busy_r))
    else $error("timer did not expire on last unit");

endmodule

/* core/ofrr_fault_ctrl.sv */
// Output over-voltage fault reaction and restart controller
`include "ofrr_cfg.svh"

// Notes on behaviour
// - Mode 10: disable output at once, then follow retry setting.
// - Mode 11: output off only while fault persists, then back on.
// - Retry 000: no restart; stay off until a clearing event.
// - Retry 111: restart without limit.
// - Retry 1..3: that many attempts, then latch off until cleared.
// - Attempt starts are spaced by delay units times unit time.
// - Latch released by status clear, clear-faults, or reset.
// - Latch also released by commanding output off then on.
// - Mode 00: ignore the fault, keep converting.
// - Mode 01: keep running for delay; if still faulted, apply retries.
// - Delay code decodes to 1,2,4,16,8,32,64,128 units.
// - Retry 4..6: that many attempts, same latch-off after failure.
module ofrr_fault_ctrl
  import ofrr_pkg::*;
(
  input wire logic clk, // System clock, 200 MHz
  input wire logic rst, // Synchronous reset, high
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [7:0] reg_addr, // Command code
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data, one cycle after strobe
  input wire logic ov_fault, // Over-voltage condition present
  input wire logic unit_tick, // One delay time unit elapsed
  input wire logic on_cmd, // Combined on/off command, high = on
  input wire logic clear_faults, // Clear-faults command, pulse
  input wire logic status_clr, // Individual status bit clear, pulse
  output logic out_en, // Power stage enable
  output logic fault_latched, // Latched-off status bit
  output logic [2:0] retries_left // Remaining attempts
);

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  logic [7:0] cfg_r, cfg_nxt, rdata_r, rdata_nxt;
  logic [1:0] mode;
  logic [2:0] retry_set, delay_code;

  // Only the documented code is writable; other codes read as zero
  always_comb begin
    cfg_nxt = cfg_r;
    rdata_nxt = rdata_r;
    if (reg_wr && reg_addr == `OFRR_REG_OFFSET) begin
      cfg_nxt = reg_wdata;
    end
    if (reg_rd) begin
      rdata_nxt = (reg_addr == `OFRR_REG_OFFSET) ? cfg_r : 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r <= `OFRR_REG_RESET;
      rdata_r <= 8'h00;
    end else begin
      cfg_r <= cfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign mode = cfg_r[`OFRR_MODE_HI:`OFRR_MODE_LO];
  assign retry_set = cfg_r[`OFRR_RETRY_HI:`OFRR_RETRY_LO];
  assign delay_code = cfg_r[`OFRR_DELAY_HI:`OFRR_DELAY_LO];
  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------
  // Delay timer
  // ----------------------------------------------------------------
  logic tmr_start, tmr_done;

  ofrr_delay_timer u_timer (
    .clk(clk),
    .rst(rst),
    .start(tmr_start),
    .unit_tick(unit_tick),
    .code(delay_code),
    .done(tmr_done),
    .busy()
  );

  // ----------------------------------------------------------------
  // Reaction state machine
  // ----------------------------------------------------------------
  ofrr_state_e state_r, state_nxt;
  logic [2:0] remain_r, remain_nxt;
  logic off_seen_r, off_seen_nxt, out_en_r, out_en_nxt;
  logic endless;

  assign endless = (retry_set == `OFRR_RETRY_ENDLESS);

  // Next state; a latch entered this cycle is not hit by a clear
  // arriving now, since clears only act from the latched state
  always_comb begin
    state_nxt = state_r;
    remain_nxt = remain_r;
    off_seen_nxt = 1'b0;
    tmr_start = 1'b0;
    case (state_r)
      OFRR_RUN: begin
        if (ov_fault) begin
          case (mode)
            `OFRR_MODE_DELAYED: begin
              state_nxt = OFRR_DLYRUN;
              tmr_start = 1'b1;
            end
            `OFRR_MODE_SHUTDOWN: begin
              remain_nxt = retry_set;
              if (retry_set == `OFRR_RETRY_NONE) begin
                state_nxt = OFRR_LATCH;
              end else begin
                state_nxt = OFRR_WAIT;
                tmr_start = 1'b1;
              end
            end
            `OFRR_MODE_WHILE_PRESENT: state_nxt = OFRR_HOLD;
            default: state_nxt = OFRR_RUN;
          endcase
        end
      end
      OFRR_DLYRUN: begin
        // Output stays on through the delay, fault checked at its end
        if (tmr_done) begin
          if (!ov_fault) begin
            state_nxt = OFRR_RUN;
          end else if (retry_set == `OFRR_RETRY_NONE) begin
            state_nxt = OFRR_LATCH;
          end else begin
            remain_nxt = retry_set;
            state_nxt = OFRR_WAIT;
            tmr_start = 1'b1;
          end
        end
      end
      OFRR_HOLD: begin
        if (!ov_fault) begin
          state_nxt = OFRR_RUN;
        end
      end
      OFRR_WAIT: begin
        if (tmr_done) begin
          state_nxt = OFRR_TRY;
          tmr_start = 1'b1;
        end
      end
      OFRR_TRY: begin
        // Attempt survives one full delay without fault to count as good.
        // A failed attempt leaves the timer running, so the next start comes
        // one delay after this one began, not one delay after the failure
        if (ov_fault) begin
          tmr_start = tmr_done; // Spacing already spent: wait a fresh delay
          if (endless) begin
            state_nxt = OFRR_WAIT;
          end else if (remain_r <= 3'h1) begin
            remain_nxt = 3'h0;
            state_nxt = OFRR_LATCH;
          end else begin
            remain_nxt = remain_r - 3'h1;
            state_nxt = OFRR_WAIT;
          end
        end else if (tmr_done) begin
          state_nxt = OFRR_RUN;
        end
      end
      OFRR_LATCH: begin
        off_seen_nxt = off_seen_r | ~on_cmd;
        if (status_clr || clear_faults) begin
          state_nxt = OFRR_RUN;
        end else if (off_seen_r && on_cmd) begin
          state_nxt = OFRR_RUN;
        end
      end
      default: state_nxt = OFRR_RUN;
    endcase
    out_en_nxt = on_cmd && (state_nxt == OFRR_RUN || state_nxt == OFRR_DLYRUN ||
                            state_nxt == OFRR_TRY);
  end

  // Reset also releases a latched fault
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= OFRR_RUN;
      remain_r <= 3'h0;
      off_seen_r <= 1'b0;
      out_en_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      remain_r <= remain_nxt;
      off_seen_r <= off_seen_nxt;
      out_en_r <= out_en_nxt;
    end
  end

  assign out_en = out_en_r;
  assign fault_latched = (state_r == OFRR_LATCH);
  assign retries_left = remain_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  shut_now_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == OFRR_RUN && ov_fault && mode == `OFRR_MODE_SHUTDOWN) |=> !out_en_r)
    else $error("shutdown mode left output on after fault");

  hold_cycle_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == OFRR_HOLD && !ov_fault && on_cmd) |=> (out_en_r && state_r == OFRR_RUN))
    else $error("output not restored after fault went away");

  no_retry_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == OFRR_RUN && ov_fault && mode == `OFRR_MODE_SHUTDOWN &&
     retry_set == `OFRR_RETRY_NONE) |=> fault_latched)
    else $error("zero retries did not latch off");

  endless_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == OFRR_TRY && ov_fault && endless) |=> (state_r == OFRR_WAIT))
    else $error("endless retry stopped retrying");

  last_fail_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == OFRR_TRY && ov_fault && !endless && remain_r == 3'h1)
    |=> (fault_latched && !out_en_r) [*2])
    else $error("last failed attempt did not latch off");

  spacing_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == OFRR_WAIT && tmr_done) |=> (state_r == OFRR_TRY))
    else $error("attempt did not start when delay expired");

  release_a: assert property (@(posedge clk) disable iff (rst)
    (fault_latched && (status_clr || clear_faults)) |=> (state_r == OFRR_RUN))
    else $error("clear did not release latched fault");

  toggle_a: assert property (@(posedge clk) disable iff (rst)
    (fault_latched && !on_cmd && !status_clr && !clear_faults ##1 on_cmd)
    |=> (state_r == OFRR_RUN))
    else $error("off then on did not release latched fault");

  ignore_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == OFRR_RUN && mode == `OFRR_MODE_IGNORE && on_cmd) |=> out_en_r)
    else $error("ignore mode interrupted the output");

  delay_run_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == OFRR_RUN && ov_fault && mode == `OFRR_MODE_DELAYED && on_cmd)
    |=> (out_en_r && state_r == OFRR_DLYRUN))
    else $error("delayed mode did not keep running");

  decrement_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == OFRR_TRY && ov_fault && !endless && remain_r > 3'h1)
    |=> (remain_r == $past(remain_r) - 3'h1 && state_r == OFRR_WAIT))
    else $error("failed attempt did not use up a retry");

  latch_c: cover property (@(posedge clk) disable iff (rst)
    state_r == OFRR_TRY ##1 state_r == OFRR_LATCH);
  recover_c: cover property (@(posedge clk) disable iff (rst)
    state_r == OFRR_TRY ##1 state_r == OFRR_RUN);
  hold_c: cover property (@(posedge clk) disable iff (rst)
    state_r == OFRR_HOLD ##1 state_r == OFRR_RUN);

endmodule

/* verification/ofrr_stage_model.sv */
// Power stage and time-unit source seen from the fault reaction block
module ofrr_stage_model #(
  parameter int TICK_CYC = 4
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, high
  input wire logic fault_req, // Bench asks for an over-voltage condition
  output logic ov_fault, // Over-voltage condition seen by the comparator
  output logic unit_tick // One delay time unit elapsed
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;

  // ----------------------------------------------------------------
  // Comparator and time base
  // ----------------------------------------------------------------
  // Comparator output is registered, like a real sampled sense path
  always_ff @(posedge clk) begin
    ov_fault <= rst ? 1'b0 : fault_req;
  end

  // Free-running unit ticks; a larger count models a slow time unit
  always_ff @(posedge clk) begin
    if (rst || cnt == TICK_CYC - 1) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
    unit_tick <= !rst && cnt == TICK_CYC - 1;
  end
endmodule

/* verification/tb.sv */
// Self-checking bench for the over-voltage fault reaction block
`include "ofrr_cfg.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
  $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 4;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, ov_fault, unit_tick, fault_req = 0;
  logic on_cmd = 1, clear_faults = 0, status_clr = 0, out_en, fault_latched;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, d;
  logic [2:0] retries_left;
  int err_count = 0, n_tests = 0, r, u;

  // ----------------------------------------------------------------
  // Clock, design and far side
  // ----------------------------------------------------------------
  always #2.5 clk = ~clk;

  ofrr_fault_ctrl u_dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .ov_fault(ov_fault), .unit_tick(unit_tick), .on_cmd(on_cmd),
    .clear_faults(clear_faults), .status_clr(status_clr), .out_en(out_en),
    .fault_latched(fault_latched), .retries_left(retries_left));

  ofrr_stage_model #(.TICK_CYC(T)) u_stage (.clk(clk), .rst(rst), .fault_req(fault_req),
    .ov_fault(ov_fault), .unit_tick(unit_tick));

  // ----------------------------------------------------------------
  // Helpers; all that wait on the clock are entered and left at a falling edge
  // ----------------------------------------------------------------
  function automatic int units(input logic [2:0] c);
    int tbl[8] = '{1, 2, 4, 16, 8, 32, 64, 128};
    return tbl[c];
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_wr = 1; reg_addr = a; reg_wdata = v; cyc(1); reg_wr = 0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_rd = 1; reg_addr = a; cyc(1); reg_rd = 0; v = reg_rdata;
  endtask

  // Reset between tests so each one starts from a known state
  task automatic start(input logic [7:0] c);
    fault_req = 0; rst = 1; cyc(2); rst = 0; wr(`OFRR_REG_OFFSET, c); cyc(2);
  endtask

  // Counts cycles where the enable differs from the expected level
  task automatic hold(input int n, input logic want);
    int bad;
    bad = 0;
    repeat (n) begin cyc(1); if (out_en !== want) bad++; end
    `CHK(bad, 0)
  endtask

  // Fault held on: count restarts; first one timed from the shutdown,
  // later ones from the start of the attempt before
  task automatic faulted(input int lim, input logic [2:0] n, output int rises);
    int t, tf;
    logic prev;
    t = 0; tf = 0; rises = 0; prev = 1; fault_req = 1;
    while (fault_latched !== 1'b1 && t < lim) begin
      cyc(1); t++;
      if (prev && !out_en && rises == 0) begin
        tf = t;
        `CHK(retries_left, n)
      end
      if (!prev && out_en) begin
        rises++;
        `CHK(t - tf >= (u - 1) * T + 1 && t - tf <= u * T + 4, 1'b1)
        tf = t;
      end
      prev = out_en;
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog sized well above the longest retry sequence
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(79));
    cyc(20); rst = 0; cyc(1);
    rd(`OFRR_REG_OFFSET, d); `CHK(d, `OFRR_REG_RESET)
    wr(8'h42, 8'hFF); rd(8'h42, d); `CHK(d, 8'h00)
    rd(`OFRR_REG_OFFSET, d); `CHK(d, `OFRR_REG_RESET)
    r = $urandom; wr(`OFRR_REG_OFFSET, r[7:0]); rd(`OFRR_REG_OFFSET, d); `CHK(d, r[7:0])
    $display("test registers done");
    // Each clearing event in turn on a latched fault
    for (int k = 0; k < 4; k++) begin
      start(8'h80);
      fault_req = 1; cyc(3);
      `CHK(out_en, 1'b0)
      fault_req = 0; cyc(20);
      `CHK(fault_latched, 1'b1)
      case (k)
        0: begin clear_faults = 1; cyc(1); clear_faults = 0; end
        1: begin status_clr = 1; cyc(1); status_clr = 0; end
        2: begin on_cmd = 0; cyc(2); on_cmd = 1; end
        default: begin rst = 1; cyc(1); rst = 0; end
      endcase
      cyc(3);
      `CHK(out_en, 1'b1)
      `CHK(fault_latched, 1'b0)
    end
    $display("test clear events done");
    // Limited retries 1..6 with random delay codes
    for (int n = 1; n <= 6; n++) begin
      d = {2'b10, 3'(n), 3'($urandom % 8)}; u = units(d[2:0]);
      start(d); faulted(20000, 3'(n), r);
      `CHK(r, n)
      `CHK(out_en, 1'b0)
    end
    $display("test limited retries done");
    u = 1; start(8'hB8); faulted(300, 3'h7, r);
    `CHK(r > 20 && fault_latched === 1'b0, 1'b1)
    // Drop the fault inside an attempt, so the next edge still fails it
    repeat (10) if (out_en !== 1'b1) cyc(1);
    fault_req = 0; hold(1, 1'b0); cyc(30); hold(50, 1'b1);
    $display("test endless retry done");
    start({2'b00, 3'($urandom % 8), 3'h0}); fault_req = 1; hold(200, 1'b1);
    $display("test ignore done");
    start({2'b11, 6'($urandom)}); fault_req = 1; cyc(3); hold(60, 1'b0);
    fault_req = 0; cyc(3); hold(40, 1'b1);
    $display("test off while present done");
    // Delayed mode: short glitch rides through, held fault trips after delay
    u = units(3'h2); start(8'h42);
    fault_req = 1; cyc(3); fault_req = 0; hold(u * T + 20, 1'b1);
    fault_req = 1; hold((u - 1) * T, 1'b1); cyc(2 * T + 6);
    `CHK(out_en, 1'b0)
    `CHK(fault_latched, 1'b1)
    // Delayed mode with one retry: fault outlasts the delay, then one attempt
    u = 1; start(8'h48); faulted(400, 3'h1, r);
    `CHK(r, 1)
    $display("test delayed mode done");
    close_out();
  end
endmodule
